// ==== acp_defs.svh ====
// register indices, command fields, reset values and counts of the serial port
`ifndef ACP_DEFS_SVH
`define ACP_DEFS_SVH
`define ACP_REG_OFFSET 3'h0
`define ACP_REG_GAIN 3'h1
`define ACP_REG_CONFIG 3'h2
`define ACP_REG_RESULT 3'h3
`define ACP_REG_SETUP 3'h4
`define ACP_SYNC_FILL_BYTE 8'hff
`define ACP_SYNC_END_BYTE 8'hfe
`define ACP_NULL_BYTE 8'h00
`define ACP_SYNC_MIN 4'hf
`define ACP_CMD_LAST 7'h07
`define ACP_SINGLE_BITS 7'h18
`define ACP_SETUP_BITS 7'h48
`define ACP_OFFSET_RESET 24'h000000
`define ACP_GAIN_RESET 24'h400000
`define ACP_CONFIG_RESET 24'h000040
`define ACP_GAIN_MAX 24'hffffff
`define ACP_CFG_PF_ENABLE 5
`endif

// ==== acp_host.sv ====
// behavioural host that frames commands and data on the serial link
`timescale 1ns/1ns
`default_nettype none
module acp_host (
  input wire logic clk,
  output logic selectN,
  output logic sclk,
  output logic serialInLine,
  input wire logic serialOutLine
);
  // idle: deselected, clock parked low so no stray edges between frames
  initial
  begin
    selectN = 1'b1;
    sclk = 1'b0;
    serialInLine = 1'b0;
  end
  // one framed transfer of n bits, 400 ns per clock half
  task automatic xfer(input logic [79:0] tx, input int n,
    output logic [71:0] rx);
    rx = '0;
    selectN <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < n; i++)
    begin
      serialInLine <= tx[79-i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      @(posedge clk);
      // sample one cycle after the rise, before the port can move on
      rx = {rx[70:0], serialOutLine};
      repeat (3) @(posedge clk);
      sclk <= 1'b0;
    end
    @(posedge clk);
    selectN <= 1'b1;
    serialInLine <= ~serialInLine; // released line shows no stale bit
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ==== acp_pkg.sv ====
// types shared by the serial command port
`default_nettype none
package acp_pkg;
  typedef enum logic {ACP_CMD, ACP_DATA} acp_mode_t;
  typedef struct packed {
    logic executableFlag;
    logic oneShotConvert;
    logic repeatConvert;
    logic dirRead;
    logic [2:0] registerSelectField;
    logic powerSaveRunSelect;
  } acp_cmd_t;
  typedef struct packed {
    logic [23:0] offsetCal;
    logic [23:0] gainCal;
    logic [23:0] configWord;
  } acp_regs_t;
  typedef struct packed {
    logic selS1;
    logic selS2;
    logic sclkS1;
    logic sclkS2;
    logic sclkS3;
    logic sdiS1;
    logic sdiS2;
    acp_mode_t mode;
    logic [6:0] bitCnt;
    logic [71:0] shiftReg;
    logic dirRead;
    logic [2:0] regSel;
    logic [3:0] syncCnt;
    acp_regs_t regs;
    logic [23:0] result;
    logic resultFresh;
    logic portFlag;
    logic convertStart;
    logic repeatOn;
    logic powerSave;
    logic serialOut;
    logic serialOutEn;
  } acp_state_t;
endpackage
`default_nettype wire

// ==== acp_serial_port.sv ====
// serial command port with result fifo
//
// Summary of operation
// - reset puts the port in command mode awaiting a command byte.
// - command mode takes eight bits as a command; stays until valid.
// - a decoded register access with select 000 to 100 switches the port into data mode.
// - single register data phase is exactly 24 serial clocks.
// - set-up transfer data phase is 72 serial clocks.
// - command register is 8 bits; data registers are 24 bits.
// - command with top bit zero other than null is a no-operation; null is all zeros.
// - only a command with top bit one is executed.
// - one-shot bit starts a single conversion.
// - repeat bit runs conversions until commanded otherwise.
// - direction bit zero writes, one reads the selected register.
// - select 000 offset, 001 gain, 010 config, 011 result read-only.
// - select 100 moves offset, gain, configuration together.
// - power-save/run bit zero runs, one enters power save unless the one-shot or repeat bit is also set.
// - null command clears the port flag during repeat conversions.
// - all-ones byte is the sync fill byte.
// - all ones but bit zero is the sync end byte.
// - register access has bit 7 set, bits 6, 5, 0 clear.
// - reset loads gain with the code for exactly one.
// - gain saturates just below four.
// - fifteen fill bytes then end byte restart framing; seen in command mode only, in data mode they are data.
// - commands arrive most significant bit first.
// - serial output is released while select is high.
// - serial clock is ignored unless select is low.
`timescale 1ns/1ns
`default_nettype none
`include "acp_defs.svh"

module acp_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wrPtr;
    logic [PW-1:0] rdPtr;
    logic [PW:0] count;
    logic notFull;
    logic notEmpty;
  } acp_fifo_state_t;
  acp_fifo_state_t st, nxt;
  logic push, pop;

  // full and empty are held in flops so both ready and valid are clean
  always_comb
  begin
    nxt = st;
    push = inValid && st.notFull;
    pop = outReady && st.notEmpty;
    if (push)
    begin
      nxt.mem[st.wrPtr] = inData;
      nxt.wrPtr = st.wrPtr + 1'b1;
    end
    if (pop)
      nxt.rdPtr = st.rdPtr + 1'b1;
    case ({push, pop})
      2'b10: nxt.count = st.count + 1'b1;
      2'b01: nxt.count = st.count - 1'b1;
      default: nxt.count = st.count;
    endcase
    nxt.notFull = (nxt.count != (PW+1)'(DEPTH));
    nxt.notEmpty = (nxt.count != '0);
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      st <= '0;
      st.notFull <= 1'b1;
    end
    else
      st <= nxt;
  end

  assign inReady = st.notFull;
  assign outValid = st.notEmpty;
  assign outData = st.mem[st.rdPtr];
endmodule

module acp_serial_port (
  input wire logic clk,
  input wire logic resetn,
  input wire logic selectN,
  input wire logic sclk,
  input wire logic serialInLine,
  output logic serialOutLine,
  output logic serialOutEn,
  input wire logic resultValid,
  input wire logic [23:0] resultData,
  output logic resultReady,
  input wire logic calGainValid,
  input wire logic [24:0] calGainValue,
  output var acp_pkg::acp_regs_t regsOut,
  output logic convertStart,
  output logic repeatConvert,
  output logic powerSave,
  output logic portFlag
);
  import acp_pkg::*;

  acp_state_t st, nxt;
  acp_cmd_t cmd;
  logic [7:0] cmdByte;
  logic selLow, rise, fall, decode, isAccess, drainLoad;
  logic fifoValid;
  logic [23:0] fifoData;

  // clamp a calibration result to the largest gain code
  function automatic logic [23:0] gain_sat(input logic [24:0] v);
    gain_sat = v[24] ? `ACP_GAIN_MAX : v[23:0];
  endfunction

  // conversion results queue here until the host has read the last one
  acp_fifo #(.WIDTH(24), .DEPTH(32)) acp_fifo_inst (
    .clk(clk),
    .resetn(resetn),
    .inValid(resultValid),
    .inData(resultData),
    .inReady(resultReady),
    .outValid(fifoValid),
    .outData(fifoData),
    .outReady(!st.resultFresh)
  );

  // edge finding on synchronised pins; first stages feed only second stages
  assign selLow = !st.selS2;
  assign rise = selLow && st.sclkS2 && !st.sclkS3;
  assign fall = selLow && !st.sclkS2 && st.sclkS3;
  assign cmdByte = {st.shiftReg[6:0], st.sdiS2};
  assign cmd = acp_cmd_t'(cmdByte);
  assign decode = rise && st.mode == ACP_CMD && st.bitCnt == `ACP_CMD_LAST;
  assign isAccess = cmd.executableFlag && !cmd.oneShotConvert &&
                    !cmd.repeatConvert && !cmd.powerSaveRunSelect;
  assign drainLoad = fifoValid && !st.resultFresh;

  // next state: sampling, command decode, data shifting, result drain
  always_comb
  begin
    nxt = st;
    nxt.convertStart = 1'b0;
    nxt.selS1 = selectN;
    nxt.selS2 = st.selS1;
    nxt.sclkS1 = sclk;
    nxt.sclkS2 = st.sclkS1;
    nxt.sclkS3 = st.sclkS2;
    nxt.sdiS1 = serialInLine;
    nxt.sdiS2 = st.sdiS1;
    nxt.serialOutEn = selLow;
    if (calGainValid)
      nxt.regs.gainCal = gain_sat(calGainValue);
    if (rise && st.mode == ACP_CMD)
    begin
      nxt.shiftReg[7:0] = cmdByte;
      nxt.bitCnt = st.bitCnt + 1'b1;
    end
    if (decode)
    begin
      nxt.bitCnt = '0;
      if (!cmd.executableFlag)
      begin
        // null clears the flag; any other such byte is ignored
        if (cmdByte == `ACP_NULL_BYTE)
          nxt.portFlag = 1'b0;
        nxt.syncCnt = '0;
      end
      else if (cmdByte == `ACP_SYNC_FILL_BYTE)
      begin
        if (st.syncCnt != `ACP_SYNC_MIN)
          nxt.syncCnt = st.syncCnt + 1'b1;
      end
      else if (cmdByte == `ACP_SYNC_END_BYTE)
      begin
        // framing restarts; registers keep their contents
        if (st.syncCnt == `ACP_SYNC_MIN)
          nxt.mode = ACP_CMD;
        nxt.syncCnt = '0;
      end
      else
      begin
        nxt.syncCnt = '0;
        if (cmd.oneShotConvert)
        begin
          nxt.convertStart = 1'b1;
          nxt.repeatOn = 1'b0;
          nxt.powerSave = 1'b0;
        end
        if (cmd.repeatConvert)
        begin
          nxt.repeatOn = 1'b1;
          nxt.powerSave = 1'b0;
        end
        if (!cmd.oneShotConvert && !cmd.repeatConvert &&
            cmd.powerSaveRunSelect)
        begin
          nxt.powerSave = 1'b1;
          nxt.repeatOn = 1'b0;
        end
        if (isAccess)
        begin
          // the run code shares its encoding with an offset write
          nxt.powerSave = 1'b0;
          if (cmd.registerSelectField <= `ACP_REG_SETUP)
          begin
            nxt.mode = ACP_DATA;
            nxt.dirRead = cmd.dirRead;
            nxt.regSel = cmd.registerSelectField;
            nxt.bitCnt = (cmd.registerSelectField == `ACP_REG_SETUP) ?
                         `ACP_SETUP_BITS : `ACP_SINGLE_BITS;
            if (cmd.dirRead)
            begin
              case (cmd.registerSelectField)
                `ACP_REG_OFFSET:
                  nxt.shiftReg = {st.regs.offsetCal, 48'h0};
                `ACP_REG_GAIN:
                  nxt.shiftReg = {st.regs.gainCal, 48'h0};
                `ACP_REG_CONFIG:
                  nxt.shiftReg = {st.regs.configWord, 48'h0};
                `ACP_REG_RESULT:
                  nxt.shiftReg = {st.result, 48'h0};
                default:
                  nxt.shiftReg = st.regs;
              endcase
              if (cmd.registerSelectField == `ACP_REG_RESULT)
                nxt.resultFresh = 1'b0;
            end
          end
        end
      end
    end
    // data phase: writes sample on rising, reads present on falling edges
    if (st.mode == ACP_DATA)
    begin
      if (fall && st.dirRead)
      begin
        nxt.serialOut = st.shiftReg[71];
        nxt.shiftReg = {st.shiftReg[70:0], 1'b0};
      end
      if (rise)
      begin
        if (!st.dirRead)
          nxt.shiftReg = {st.shiftReg[70:0], st.sdiS2};
        nxt.bitCnt = st.bitCnt - 1'b1;
        if (st.bitCnt == 7'h01)
        begin
          nxt.mode = ACP_CMD;
          nxt.bitCnt = '0;
          nxt.serialOut = 1'b0;
          if (!st.dirRead)
          begin
            case (st.regSel)
              `ACP_REG_OFFSET:
                nxt.regs.offsetCal = {st.shiftReg[22:0], st.sdiS2};
              `ACP_REG_GAIN:
                nxt.regs.gainCal = {st.shiftReg[22:0], st.sdiS2};
              `ACP_REG_CONFIG:
                nxt.regs.configWord = {st.shiftReg[22:0], st.sdiS2};
              `ACP_REG_SETUP:
                nxt.regs = {st.shiftReg[70:0], st.sdiS2};
              default:
                nxt.regs = st.regs; // result register is read-only
            endcase
          end
        end
      end
    end
    // a new result in repeat mode with the flag enabled wins over a null clear in the same cycle
    if (drainLoad)
    begin
      nxt.result = fifoData;
      nxt.resultFresh = 1'b1;
      if (st.repeatOn && st.regs.configWord[`ACP_CFG_PF_ENABLE])
        nxt.portFlag = 1'b1;
    end
  end

  // synchronous reset to command mode with default register values
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      st <= '0;
      st.selS1 <= 1'b1;
      st.selS2 <= 1'b1;
      st.mode <= ACP_CMD;
      st.regs.offsetCal <= `ACP_OFFSET_RESET;
      st.regs.gainCal <= `ACP_GAIN_RESET;
      st.regs.configWord <= `ACP_CONFIG_RESET;
    end
    else
      st <= nxt;
  end

  assign serialOutLine = st.serialOut;
  assign serialOutEn = st.serialOutEn;
  assign regsOut = st.regs;
  assign convertStart = st.convertStart;
  assign repeatConvert = st.repeatOn;
  assign powerSave = st.powerSave;
  assign portFlag = st.portFlag;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  reset_cmd_mode_a: assert property (disable iff (1'b0)
    !resetn |=> st.mode == ACP_CMD && st.bitCnt == 7'h00)
    else $error("port not in command mode after reset");
  gain_reset_a: assert property (disable iff (1'b0)
    !resetn |=> st.regs.gainCal == 24'h400000)
    else $error("gain not one after reset");
  data_entry_a: assert property (decode && isAccess &&
    cmd.registerSelectField <= 3'h4 && cmdByte != 8'hfe |=> st.mode == ACP_DATA)
    else $error("valid access did not enter data mode");
  single_len_a: assert property (decode && isAccess &&
    cmd.registerSelectField < 3'h4 |=> st.bitCnt == 7'h18)
    else $error("single access length wrong");
  setup_len_a: assert property (decode && isAccess &&
    cmd.registerSelectField == 3'h4 |=> st.bitCnt == 7'h48)
    else $error("setup access length wrong");
  null_stay_a: assert property (decode && !cmd.executableFlag |=>
    st.mode == ACP_CMD && st.bitCnt == 7'h00)
    else $error("non executable byte left command mode");
  oneshot_start_a: assert property (st.convertStart |->
    $past(decode) && $past(cmd.oneShotConvert) && $past(cmd.executableFlag))
    else $error("conversion start without one-shot command");
  repeat_cause_a: assert property ($rose(st.repeatOn) |->
    $past(decode && cmd.repeatConvert))
    else $error("repeat mode without command");
  reserved_noop_a: assert property (decode && isAccess &&
    cmd.registerSelectField > 3'h4 && !calGainValid |=> $stable(st.regs) &&
    st.mode == ACP_CMD) else $error("reserved select touched registers");
  return_cmd_a: assert property (st.mode == ACP_DATA && rise &&
    st.bitCnt == 7'h01 |=> st.mode == ACP_CMD ##1 st.mode == ACP_CMD)
    else $error("no return to command mode");
  flag_clear_a: assert property (decode && cmdByte == 8'h00 &&
    !drainLoad |=> !st.portFlag) else $error("null did not clear port flag");
  out_release_a: assert property (st.selS2 |=> !serialOutEn)
    else $error("serial output driven while deselected");
  clk_ignored_a: assert property (st.selS2 |=>
    $stable(st.bitCnt) && $stable(st.mode))
    else $error("serial clock acted while deselected");

  cover_setup_write: cover property (st.mode == ACP_DATA &&
    st.regSel == 3'h4 && !st.dirRead ##1 st.mode == ACP_CMD);
  cover_result_read: cover property (decode && isAccess && cmd.dirRead &&
    cmd.registerSelectField == 3'h3);
  cover_resync: cover property (decode && cmdByte == 8'hfe &&
    st.syncCnt == 4'hf);
  cover_fifo_full: cover property (!resultReady);
endmodule
`default_nettype wire

// ==== acp_serial_port_tb.sv ====
// self-checking bench for the serial command port and its result fifo
`timescale 1ns/1ns
`default_nettype none
module acp_serial_port_tb;
  import acp_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic selectN, sclk, serialInLine, serialOutLine, serialOutEn;
  logic resultValid = 1'b0;
  logic [23:0] resultData = 24'h000000;
  logic resultReady, convertStart, repeatConvert, powerSave, portFlag;
  logic calGainValid = 1'b0;
  logic [24:0] calGainValue = 25'h0000000;
  acp_regs_t regsOut;
  int failCount = 0;
  int checkCount = 0;
  int startCnt = 0;
  int seed = 11;
  int acc;
  logic [71:0] expQ[$];
  string nameQ[$];
  logic [71:0] obsVal = '0;
  logic [7:0] obsSeq = 8'h00;
  logic [7:0] seenSeq = 8'h00;
  logic [71:0] rx, regsExp;
  logic [23:0] rnd;
  logic [7:0] junk[4] = '{8'h8a, 8'h9c, 8'h8e, 8'h12};
  always #50 clk = ~clk;
  acp_serial_port acp_serial_port_inst (.clk(clk), .resetn(resetn),
    .selectN(selectN), .sclk(sclk), .serialInLine(serialInLine),
    .serialOutLine(serialOutLine), .serialOutEn(serialOutEn),
    .resultValid(resultValid), .resultData(resultData),
    .resultReady(resultReady), .calGainValid(calGainValid),
    .calGainValue(calGainValue), .regsOut(regsOut),
    .convertStart(convertStart), .repeatConvert(repeatConvert),
    .powerSave(powerSave), .portFlag(portFlag));
  acp_host acp_host_inst (.clk(clk), .selectN(selectN), .sclk(sclk),
    .serialInLine(serialInLine), .serialOutLine(serialOutLine));
  // start pulses last one cycle, so they are counted as they pass
  always @(posedge clk)
    if (convertStart === 1'b1) startCnt++;
  // watcher: each new observation is matched against the oldest note
  always @(posedge clk)
  begin
    if (obsSeq !== seenSeq)
    begin
      seenSeq = obsSeq;
      checkCount++;
      if (obsVal !== expQ[0])
      begin
        $display("MISMATCH %s expected %h seen %h", nameQ[0], expQ[0],
          obsVal);
        failCount++;
      end
      void'(expQ.pop_front());
      void'(nameQ.pop_front());
    end
  end
  task automatic see(input string nm, input logic [71:0] e,
    input logic [71:0] g);
    expQ.push_back(e);
    nameQ.push_back(nm);
    obsVal <= g;
    obsSeq <= obsSeq + 8'h01;
    @(posedge clk);
  endtask
  // command byte followed by n data bits taken msb-aligned from d
  task automatic cmd(input logic [7:0] c, input logic [71:0] d,
    input int n);
    acp_host_inst.xfer({c, d}, n + 8, rx);
  endtask
  task automatic note(input string t);
    $display("test %s done", t);
  endtask
  task automatic stopTest();
    $display("checks %0d mismatches %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard, far beyond the expected run length
  initial
  begin
    #5000000;
    failCount++;
    stopTest();
  end
  initial
  begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    regsExp = 72'h000000400000000040;
    see("regs", regsExp, regsOut);
    // fill the fifo with nobody reading, then drain it over the link
    acc = 0;
    resultValid <= 1'b1;
    resultData <= 24'h5a0000;
    for (int i = 0; i < 40; i++)
    begin
      @(posedge clk);
      if (resultReady === 1'b1) acc++;
      resultData <= 24'h5a0000 + 24'(acc);
    end
    resultValid <= 1'b0;
    see("accepted", 72'd33, 72'(acc));
    for (int k = 0; k < 33; k++)
    begin
      cmd(8'h96, 72'h0, 24);
      see("result", 72'(24'h5a0000 + 24'(k)), 72'(rx[23:0]));
    end
    note("fifo");
    for (int s = 0; s < 3; s++)
    begin
      rnd = $random(seed);
      cmd(8'h80 | 8'(s << 1), {rnd, 48'h0}, 24);
      cmd(8'h90 | 8'(s << 1), 72'h0, 24);
      see("readback", 72'(rnd), 72'(rx[23:0]));
      regsExp[71-24*s -: 24] = rnd;
    end
    cmd(8'h86, {24'hffffff, 48'h0}, 24);
    see("regs", regsExp, regsOut);
    see("release", 72'h0, 72'(serialOutEn));
    rnd = $random(seed);
    regsExp = {rnd, ~rnd, rnd ^ 24'h00ff00};
    cmd(8'h88, regsExp, 72);
    cmd(8'h98, 72'h0, 72);
    see("setup", regsExp, rx);
    see("regs", regsExp, regsOut);
    note("registers");
    foreach (junk[i]) cmd(junk[i], 72'h0, 0);
    cmd(8'h92, 72'h0, 24);
    see("gain", 72'(regsExp[47:24]), 72'(rx[23:0]));
    for (int i = 0; i < 15; i++) cmd(8'hff, 72'h0, 0);
    cmd(8'hfe, 72'h0, 0);
    cmd(8'h94, 72'h0, 24);
    see("config", 72'(regsExp[23:0]), 72'(rx[23:0]));
    note("framing");
    cmd(8'ha0, 72'h0, 0);
    see("repeat", 72'h1, 72'(repeatConvert));
    cmd(8'hc0, 72'h0, 0);
    see("starts", 72'h1, 72'(startCnt));
    see("repeatOff", 72'h0, 72'(repeatConvert));
    cmd(8'h81, 72'h0, 0);
    see("save", 72'h1, 72'(powerSave));
    cmd(8'h80, {regsExp[71:48], 48'h0}, 24);
    see("run", 72'h0, 72'(powerSave));
    // port flag: enable it, run repeat mode, deliver one result
    cmd(8'h84, {24'h000060, 48'h0}, 24);
    cmd(8'ha0, 72'h0, 0);
    resultValid <= 1'b1;
    resultData <= 24'h123456;
    @(posedge clk);
    resultValid <= 1'b0;
    repeat (4) @(posedge clk);
    see("flagSet", 72'h1, 72'(portFlag));
    cmd(8'h00, 72'h0, 0);
    see("flagClr", 72'h0, 72'(portFlag));
    note("commands");
    calGainValue <= 25'h1000000;
    calGainValid <= 1'b1;
    @(posedge clk);
    calGainValid <= 1'b0;
    repeat (2) @(posedge clk);
    see("gainSat", 72'hffffff, 72'(regsOut.gainCal));
    // second reset in mid-run restores defaults and command mode
    resetn <= 1'b0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    cmd(8'h92, 72'h0, 24);
    see("gainReset", 72'h400000, 72'(rx[23:0]));
    note("reset");
    repeat (4) @(posedge clk);
    stopTest();
  end
endmodule
`default_nettype wire
